/* File: logic/oda_pkg.sv */
// Purpose: Shared constants and types for the octal DAC two-wire command slave
// Assumes: One 50 MHz core clock; bus pins arrive unsynchronised
// Notes: Wishbone register map and command codes live here
//
// Overview of operation
// [RULE_01] Standard reset puts DAC registers at zero-scale
// [RULE_02] Parameter selects mid-scale reset preset instead
// [RULE_03] Data bits sampled on serial clock rising edge
// [RULE_04] Data line released except low acknowledge slots
// [RULE_05] Command 0000 writes selected input register only
// [RULE_06] Command 0001 updates selected DAC and powers up
// [RULE_07] Command 0010 writes input, updates all channels
// [RULE_08] Command 0011 writes and updates selected channel
// [RULE_09] Command 0100 powers down, registers kept intact
// [RULE_10] Master sends only listed command and channel codes
// [RULE_11] Code 1111 and reserved codes do nothing
// [RULE_12] Channel codes 0-7 map A-H, 1111 all
// [RULE_13] Byte one command/channel, then data MSB first
// [RULE_14] Read requests get no acknowledge and no data
// [RULE_15] Start is data falling while clock high
// [RULE_16] Stop is data rising while clock high
// [RULE_17] Master leaves both lines high when idle
// [RULE_18] Acknowledge held low through whole clock high
// [RULE_19] Three tri-state straps choose one of 27 addresses
// [RULE_20] Address is index+4 in bits 6,5,4,1,0
// [RULE_21] Fixed global address also accepted
// [RULE_22] Acknowledge matching address and three data bytes
// [RULE_23] Execute after third byte, refuse later bytes

package oda_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int NUM_CH = 8;
  localparam int CODE_W = 16;
  localparam int BYTE_W = 8;

  // ************************************************************
  // Command and channel codes
  // ************************************************************
  localparam logic [3:0] CMD_WRITE = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
  localparam logic [3:0] CMD_NOP = 4'hf;
  localparam logic [3:0] CHAN_ALL = 4'hf;
  localparam logic [3:0] CHAN_LAST = 4'h7;

  // ************************************************************
  // Addressing
  // ************************************************************
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [4:0] STRAP_W2 = 5'h09;
  localparam logic [4:0] STRAP_W1 = 5'h03;
  localparam logic [4:0] ADDR_BIAS = 5'h04;
  localparam logic [6:0] GLOBAL_ADDR = 7'h73;

  // ************************************************************
  // Reset codes
  // ************************************************************
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;

  // ************************************************************
  // Frame positions
  // ************************************************************
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] BYTE_ADDR = 3'h0;
  localparam logic [2:0] BYTE_LAST = 3'h3;
  localparam logic [2:0] BYTE_EXTRA = 3'h4;

  // ************************************************************
  // Wishbone register map
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAST_CMD = 8'h08;
  localparam logic [7:0] REG_INPUT_BASE = 8'h40;
  localparam logic [7:0] REG_DAC_BASE = 8'h60;
  localparam logic [7:0] REG_BANK_MASK = 8'he0;
  localparam int CTRL_EN_BIT = 0;
  localparam int STATUS_BUSY_BIT = 8;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } oda_line_t;

  typedef struct packed {
    logic [3:0] cmd_code;
    logic [3:0] channel_select;
    logic [15:0] data;
  } oda_cmd_t;

  typedef logic [NUM_CH-1:0][CODE_W-1:0] oda_bank_t;

endpackage

/* File: logic/oda_line_sync.sv */
// Purpose: Synchronise serial clock and data pins and find bus events
// Assumes: Pins are asynchronous to the core clock
// Notes: Events are one-cycle pulses in the core clock domain
`timescale 1ns/1ps
`default_nettype none

module oda_line_sync (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output oda_pkg::oda_line_t line_o
);

  logic [2:0] scl_r;
  logic [2:0] sda_r;

  // ************************************************************
  // Two-stage synchronisers plus history stage
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_r <= 3'h7;
      sda_r <= 3'h7;
    end else begin
      scl_r <= {scl_r[1:0], scl_i};
      sda_r <= {sda_r[1:0], sda_i};
    end
  end

  // ************************************************************
  // Event detection
  // ************************************************************
  always_comb begin
    line_o.scl_rise = scl_r[1] & ~scl_r[2]; // RULE_03
    line_o.scl_fall = ~scl_r[1] & scl_r[2];
    line_o.start = scl_r[1] & scl_r[2] & sda_r[2] & ~sda_r[1]; // RULE_15
    line_o.stop = scl_r[1] & scl_r[2] & ~sda_r[2] & sda_r[1]; // RULE_16
    line_o.sda = sda_r[1];
  end

endmodule

`default_nettype wire

/* File: logic/oda_dac_slave.sv */
// Purpose: Two-wire write-only command slave for an eight-channel DAC
// Assumes: Core clock far faster than the serial clock
// Notes: Wishbone classic slave gives enable, status and readback
`timescale 1ns/1ps
`default_nettype none

module oda_dac_slave #(
  parameter bit MIDSCALE_POR = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [1:0] addr_strap_0_i,
  input wire logic [1:0] addr_strap_1_i,
  input wire logic [1:0] addr_strap_2_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output oda_pkg::oda_bank_t channel_output_o,
  output logic [7:0] power_down_o
);

  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_ACK, ST_NACK} oda_state_t;

  localparam logic [15:0] CODE_POR = MIDSCALE_POR ? oda_pkg::CODE_MID : oda_pkg::CODE_ZERO; // RULE_01 RULE_02

  oda_pkg::oda_line_t line;
  oda_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [2:0] byte_cnt_r;
  logic [7:0] shift_r;
  logic [15:0] word_r;
  logic exec_r;
  oda_pkg::oda_cmd_t cmd_r;
  oda_pkg::oda_cmd_t last_cmd_r;
  logic [1:0] strap0_a_r, strap0_b_r;
  logic [1:0] strap1_a_r, strap1_b_r;
  logic [1:0] strap2_a_r, strap2_b_r;
  logic [6:0] own_addr;
  logic addr_ok;
  logic enable_r;
  oda_pkg::oda_bank_t input_r;
  oda_pkg::oda_bank_t dac_r;
  logic [7:0] pd_r;
  oda_pkg::oda_bank_t input_nxt;
  oda_pkg::oda_bank_t dac_nxt;
  logic [7:0] pd_nxt;
  logic [7:0] sel_mask;
  logic wb_req;
  logic [31:0] rd_nxt;

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic [4:0] strap_weight(input logic [1:0] s);
    case (s)
      oda_pkg::STRAP_LOW: strap_weight = 5'h00;
      oda_pkg::STRAP_HIGH: strap_weight = 5'h02;
      default: strap_weight = 5'h01;
    endcase
  endfunction

  function automatic logic [7:0] chan_mask(input logic [3:0] ch);
    if (ch == oda_pkg::CHAN_ALL) begin
      chan_mask = 8'hff; // RULE_12
    end else if (ch <= oda_pkg::CHAN_LAST) begin
      chan_mask = 8'(8'h01 << ch[2:0]); // RULE_12
    end else begin
      chan_mask = 8'h00; // RULE_11
    end
  endfunction

  // ************************************************************
  // Pin front end
  // ************************************************************
  oda_line_sync u_line (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .line_o(line)
  );

  // ************************************************************
  // Strap synchronisers and address
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap0_a_r <= oda_pkg::STRAP_FLOAT;
      strap0_b_r <= oda_pkg::STRAP_FLOAT;
      strap1_a_r <= oda_pkg::STRAP_FLOAT;
      strap1_b_r <= oda_pkg::STRAP_FLOAT;
      strap2_a_r <= oda_pkg::STRAP_FLOAT;
      strap2_b_r <= oda_pkg::STRAP_FLOAT;
    end else begin
      strap0_a_r <= addr_strap_0_i;
      strap0_b_r <= strap0_a_r;
      strap1_a_r <= addr_strap_1_i;
      strap1_b_r <= strap1_a_r;
      strap2_a_r <= addr_strap_2_i;
      strap2_b_r <= strap2_a_r;
    end
  end

  always_comb begin
    logic [4:0] idx;
    idx = 5'(strap_weight(strap2_b_r) * oda_pkg::STRAP_W2) + 5'(strap_weight(strap1_b_r) * oda_pkg::STRAP_W1)
          + strap_weight(strap0_b_r) + oda_pkg::ADDR_BIAS; // RULE_19 RULE_20
    own_addr = {idx[4:2], 2'b00, idx[1:0]}; // RULE_20
    addr_ok = ((shift_r[7:1] == own_addr) || (shift_r[7:1] == oda_pkg::GLOBAL_ADDR)) // RULE_21
              && !shift_r[0] && enable_r; // RULE_14
  end

  // ************************************************************
  // Frame state machine
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      byte_cnt_r <= 3'h0;
    end else if (line.stop) begin
      state_r <= ST_IDLE; // RULE_16
    end else if (line.start) begin
      state_r <= ST_RX; // RULE_15
      bit_cnt_r <= 4'h0;
      byte_cnt_r <= oda_pkg::BYTE_ADDR;
    end else begin
      case (state_r)
        ST_RX: begin
          if (line.scl_rise && bit_cnt_r != oda_pkg::BITS_PER_BYTE) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (line.scl_fall && bit_cnt_r == oda_pkg::BITS_PER_BYTE) begin
            bit_cnt_r <= 4'h0;
            if (byte_cnt_r != oda_pkg::BYTE_EXTRA) begin
              byte_cnt_r <= byte_cnt_r + 3'h1;
            end
            if (byte_cnt_r == oda_pkg::BYTE_ADDR) begin
              state_r <= addr_ok ? ST_ACK : ST_IDLE; // RULE_22 RULE_14
            end else if (byte_cnt_r == oda_pkg::BYTE_EXTRA) begin
              state_r <= ST_NACK; // RULE_23
            end else begin
              state_r <= ST_ACK; // RULE_22
            end
          end
        end
        ST_ACK, ST_NACK: begin
          if (line.scl_fall) begin
            state_r <= ST_RX;
          end
        end
        ST_IDLE: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Bit shifter and command word
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_r <= 8'h00;
      word_r <= 16'h0000;
    end else if (state_r == ST_RX && line.scl_rise && bit_cnt_r != oda_pkg::BITS_PER_BYTE) begin
      shift_r <= {shift_r[6:0], line.sda}; // RULE_03 RULE_13
    end else if (state_r == ST_RX && line.scl_fall && bit_cnt_r == oda_pkg::BITS_PER_BYTE) begin
      word_r <= {word_r[7:0], shift_r}; // RULE_13
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exec_r <= 1'b0;
      cmd_r <= '0;
      last_cmd_r <= '0;
    end else begin
      exec_r <= 1'b0;
      if (state_r == ST_RX && !line.stop && !line.start && line.scl_fall
          && bit_cnt_r == oda_pkg::BITS_PER_BYTE && byte_cnt_r == oda_pkg::BYTE_LAST) begin
        exec_r <= 1'b1; // RULE_23
        cmd_r <= {word_r, shift_r}; // RULE_13
        last_cmd_r <= {word_r, shift_r};
      end
    end
  end

  // ************************************************************
  // Data line drive
  // ************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_o <= 1'b0; // RULE_04
      if (line.stop || line.start) begin
        sda_oe_n_o <= 1'b1;
      end else if (state_r == ST_RX && line.scl_fall && bit_cnt_r == oda_pkg::BITS_PER_BYTE) begin
        sda_oe_n_o <= !((byte_cnt_r == oda_pkg::BYTE_ADDR) ? addr_ok
                        : (byte_cnt_r != oda_pkg::BYTE_EXTRA)); // RULE_04 RULE_18 RULE_22 RULE_23
      end else if (line.scl_fall) begin
        sda_oe_n_o <= 1'b1; // RULE_04 RULE_18
      end
    end
  end

  // ************************************************************
  // Command execution
  // ************************************************************
  always_comb begin
    input_nxt = input_r;
    dac_nxt = dac_r;
    pd_nxt = pd_r;
    sel_mask = chan_mask(cmd_r.channel_select);
    if (exec_r) begin
      for (int i = 0; i < oda_pkg::NUM_CH; i++) begin
        case (cmd_r.cmd_code)
          oda_pkg::CMD_WRITE: begin
            if (sel_mask[i]) begin
              input_nxt[i] = cmd_r.data; // RULE_05
            end
          end
          oda_pkg::CMD_UPDATE: begin
            if (sel_mask[i]) begin
              dac_nxt[i] = input_r[i]; // RULE_06
              pd_nxt[i] = 1'b0;
            end
          end
          oda_pkg::CMD_WRITE_UPD_ALL: begin
            input_nxt[i] = sel_mask[i] ? cmd_r.data : input_r[i]; // RULE_07
            if (sel_mask != 8'h00) begin
              dac_nxt[i] = input_nxt[i]; // RULE_07
              pd_nxt[i] = 1'b0;
            end
          end
          oda_pkg::CMD_WRITE_UPD: begin
            if (sel_mask[i]) begin
              input_nxt[i] = cmd_r.data; // RULE_08
              dac_nxt[i] = cmd_r.data;
              pd_nxt[i] = 1'b0;
            end
          end
          oda_pkg::CMD_POWER_DOWN: begin
            if (sel_mask[i]) begin
              pd_nxt[i] = 1'b1; // RULE_09
            end
          end
          default: begin
            pd_nxt[i] = pd_r[i]; // RULE_11
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      input_r <= {oda_pkg::NUM_CH{CODE_POR}};
      dac_r <= {oda_pkg::NUM_CH{CODE_POR}}; // RULE_01 RULE_02
      pd_r <= 8'h00;
    end else begin
      input_r <= input_nxt;
      dac_r <= dac_nxt;
      pd_r <= pd_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_output_o <= {oda_pkg::NUM_CH{CODE_POR}};
      power_down_o <= 8'h00;
    end else begin
      channel_output_o <= dac_nxt;
      power_down_o <= pd_nxt;
    end
  end

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i == oda_pkg::REG_CTRL) begin
      rd_nxt[oda_pkg::CTRL_EN_BIT] = enable_r;
    end else if (wb_adr_i == oda_pkg::REG_STATUS) begin
      rd_nxt[7:0] = pd_r;
      rd_nxt[oda_pkg::STATUS_BUSY_BIT] = (state_r != ST_IDLE);
    end else if (wb_adr_i == oda_pkg::REG_LAST_CMD) begin
      rd_nxt[23:0] = last_cmd_r;
    end else if ((wb_adr_i & oda_pkg::REG_BANK_MASK) == oda_pkg::REG_INPUT_BASE && wb_adr_i[1:0] == 2'b00) begin
      rd_nxt[15:0] = input_r[wb_adr_i[4:2]];
    end else if ((wb_adr_i & oda_pkg::REG_BANK_MASK) == oda_pkg::REG_DAC_BASE && wb_adr_i[1:0] == 2'b00) begin
      rd_nxt[15:0] = dac_r[wb_adr_i[4:2]];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_r <= 1'b1;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == oda_pkg::REG_CTRL) begin
      enable_r <= wb_dat_i[oda_pkg::CTRL_EN_BIT];
    end
  end

endmodule

`default_nettype wire

/* File: tb/oda_dac_slave_properties.sv */
// Purpose: Concurrent checks on the octal DAC command slave ports
// Assumes: Bound to every instance of the top module
// Notes: Helper logic follows frames on the raw pins
`timescale 1ns/1ps
`default_nettype none

module oda_dac_slave_properties #(
  parameter bit MIDSCALE_POR = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire oda_pkg::oda_bank_t channel_output_o,
  input wire logic [7:0] power_down_o
);
  // ************************************************************
  // Frame tracking
  // ************************************************************
  logic in_frame_r;
  logic rd_r;
  logic [3:0] nbit_r;
  logic [2:0] acks_r;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_frame_r <= 1'b0;
      rd_r <= 1'b0;
      nbit_r <= 4'h0;
      acks_r <= 3'h0;
    end else if (scl_i && $fell(sda_i)) begin
      in_frame_r <= 1'b1;
      rd_r <= 1'b0;
      nbit_r <= 4'h0;
      acks_r <= 3'h0;
    end else begin
      if (scl_i && $rose(sda_i)) in_frame_r <= 1'b0;
      if ($rose(scl_i) && nbit_r != 4'hf) nbit_r <= nbit_r + 4'h1;
      if ($rose(scl_i) && nbit_r == 4'h7 && sda_i) rd_r <= 1'b1;
      if ($fell(sda_oe_n_o) && acks_r != 3'h7) acks_r <= acks_r + 3'h1;
    end
  end

  // ************************************************************
  // Properties
  // ************************************************************
  sequence s_ack_begin;
    $fell(sda_oe_n_o);
  endsequence
  sequence s_wb_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  property p_wb_ack;
    s_wb_taken |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_drive_low;
    !sda_oe_n_o |-> !sda_o;
  endproperty
  property p_drive_begin;
    s_ack_begin |-> !scl_i && in_frame_r;
  endproperty
  property p_drive_bounded;
    s_ack_begin |-> ##[1:40] sda_oe_n_o;
  endproperty
  property p_hold_high;
    $rose(sda_oe_n_o) |-> !scl_i;
  endproperty
  property p_por;
    $rose(rst_n_i) |-> power_down_o == 8'h00 &&
      channel_output_o == {oda_pkg::NUM_CH{MIDSCALE_POR ? oda_pkg::CODE_MID : oda_pkg::CODE_ZERO}};
  endproperty
  property p_pd_keeps;
    (power_down_o & ~$past(power_down_o)) != 8'h00 |-> $stable(channel_output_o);
  endproperty
  property p_read_nack;
    rd_r |-> sda_oe_n_o;
  endproperty
  property p_ack_count;
    s_ack_begin |-> acks_r < 3'h4;
  endproperty

  a_wb_ack: assert property (p_wb_ack) else $error("bus ack not one cycle after request");
  a_drive_low: assert property (p_drive_low) else $error("data driven high");
  a_drive_begin: assert property (p_drive_begin) else $error("ack drive outside slot");
  a_drive_bounded: assert property (p_drive_bounded) else $error("ack drive too long");
  a_hold_high: assert property (p_hold_high) else $error("ack released in clock high");
  a_por: assert property (p_por) else $error("wrong reset code");
  a_pd_keeps: assert property (p_pd_keeps) else $error("power down changed codes");
  a_read_nack: assert property (p_read_nack) else $error("read request acknowledged");
  a_ack_count: assert property (p_ack_count) else $error("extra byte acknowledged");
endmodule

`default_nettype wire

/* File: tb/oda_i2c_master.sv */
// Purpose: Two-wire bus master model for the DAC slave
// Assumes: Wire resolved with a pull-up in the bench
// Notes: Half phase of 4 core clocks, 160 ns bit period
`timescale 1ns/1ps
`default_nettype none

module oda_i2c_master (
  input wire logic core_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // ************************************************************
  // Bus phases
  // ************************************************************
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic half();
    repeat (4) @(posedge core_clk_i);
  endtask

  task automatic start();
    @(posedge core_clk_i);
    sda_pull_o <= 1'b1;
    half();
    scl_o <= 1'b0;
  endtask

  task automatic stop();
    @(posedge core_clk_i);
    sda_pull_o <= 1'b1;
    half();
    scl_o <= 1'b1;
    half();
    sda_pull_o <= 1'b0;
    half();
  endtask

  task automatic put_bit(input logic b, output logic seen);
    @(posedge core_clk_i);
    sda_pull_o <= ~b;
    repeat (3) @(posedge core_clk_i);
    scl_o <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    seen = sda_i;
    repeat (2) @(posedge core_clk_i);
    scl_o <= 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule

`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the octal DAC command slave
// Assumes: Master model drives the serial pins, bench drives Wishbone
// Notes: Random straps, commands and data, fixed seed
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [1:0] s0 = 2'h0;
  logic [1:0] s1 = 2'h0;
  logic [1:0] s2 = 2'h0;
  logic [31:0] rdat;
  logic ack, scl, pull, so_a, oe_a, so_b, oe_b;
  wire sda = ~(pull | (~oe_a & ~so_a) | (~oe_b & ~so_b));
  oda_pkg::oda_bank_t dac_a;
  oda_pkg::oda_bank_t dac_b;
  logic [7:0] pd_a;
  logic [15:0] e_in [8];
  logic [15:0] e_dac [8];
  logic [7:0] e_pd;
  logic [3:0] cmds [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf, 4'h5, 4'h9};
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #10 core_clk = ~core_clk;

  oda_dac_slave i_oda_dac_slave (.core_clk_i(core_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(so_a), .sda_oe_n_o(oe_a), .addr_strap_0_i(s0), .addr_strap_1_i(s1), .addr_strap_2_i(s2),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
    .wb_dat_o(rdat), .wb_ack_o(ack), .channel_output_o(dac_a), .power_down_o(pd_a));
  oda_dac_slave #(.MIDSCALE_POR(1'b1)) i_oda_dac_slave_mid (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .scl_i(scl), .sda_i(sda), .sda_o(so_b), .sda_oe_n_o(oe_b), .addr_strap_0_i(s0), .addr_strap_1_i(s1),
    .addr_strap_2_i(s2), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_sel_i(4'hf), .wb_dat_o(), .wb_ack_o(), .channel_output_o(dac_b), .power_down_o());
  oda_i2c_master i_oda_i2c_master (.core_clk_i(core_clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge core_clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic frame(input logic [6:0] a, input logic rd, input int nb, input logic [23:0] w,
                       output logic [4:0] acks);
    logic k;
    acks = 5'h00;
    i_oda_i2c_master.start();
    i_oda_i2c_master.put_byte({a, rd}, k);
    acks[0] = k;
    for (int i = 0; i < nb; i++) begin
      i_oda_i2c_master.put_byte(i < 3 ? w[23-8*i -: 8] : 8'h5a, k);
      acks[i+1] = k;
    end
    i_oda_i2c_master.stop();
    repeat (8) @(posedge core_clk);
  endtask

  function automatic logic [6:0] addr_of(input logic [1:0] a2, input logic [1:0] a1, input logic [1:0] a0);
    logic [4:0] x;
    x = 5'(9 * a2 + 3 * a1 + a0 + 4);
    return {x[4:2], 2'b00, x[1:0]};
  endfunction

  function automatic void apply(input logic [3:0] c, input logic [3:0] ch, input logic [15:0] d);
    for (int k = 0; k < 8; k++) begin
      if (ch == 4'hf || ch == 4'(k)) begin
        if (c == 4'h0 || c == 4'h2 || c == 4'h3) e_in[k] = d;
        if (c == 4'h1 || c == 4'h3) e_dac[k] = e_in[k];
        if (c == 4'h1 || c == 4'h3) e_pd[k] = 1'b0;
        if (c == 4'h4) e_pd[k] = 1'b1;
      end
    end
    for (int k = 0; k < 8; k++) begin
      if (c == 4'h2 && (ch == 4'hf || ch <= 4'h7)) begin
        e_dac[k] = e_in[k];
        e_pd[k] = 1'b0;
      end
    end
  endfunction

  task automatic check_outs();
    for (int k = 0; k < 8; k++) chk("dac", dac_a[k], e_dac[k]);
    chk("power", pd_a, e_pd);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [31:0] q;
    logic [4:0] ak;
    logic [3:0] c;
    logic [3:0] ch;
    logic [15:0] d;
    logic [6:0] own;
    int r;
    void'($urandom(74));
    for (int k = 0; k < 8; k++) begin
      e_in[k] = 16'h0000;
      e_dac[k] = 16'h0000;
    end
    e_pd = 8'h00;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    for (int k = 0; k < 8; k++) chk("dac_mid", dac_b[k], 16'h8000);
    check_outs();
    wb(1'b0, 8'h00, 32'h0, q);
    chk("ctrl", q, 32'h1);
    wb(1'b1, 8'h3c, 32'hffff_ffff, q);
    wb(1'b0, 8'h3c, 32'h0, q);
    chk("unmapped", q, 32'h0);
    for (int n = 0; n < 6; n++) begin
      s0 <= n == 0 ? 2'h2 : 2'($urandom_range(2));
      s1 <= n == 0 ? 2'h2 : 2'($urandom_range(2));
      s2 <= n == 0 ? 2'h2 : 2'($urandom_range(2));
      repeat (4) @(posedge core_clk);
      own = addr_of(s2, s1, s0);
      frame(own, 1'b0, 3, 24'hf0_0000, ak);
      chk("own", ak, 5'h0f);
      frame(own ^ 7'h04, 1'b0, 0, 24'h0, ak);
      chk("other", ak, 5'h00);
      frame(own, 1'b1, 0, 24'h0, ak);
      chk("read", ak, 5'h00);
    end
    for (int n = 0; n < 24; n++) begin
      c = n < 8 ? cmds[n] : cmds[$urandom_range(5)];
      r = n == 2 ? 9 : $urandom_range(8);
      ch = r == 8 ? 4'hf : (r == 9 ? 4'h8 : 4'(r));
      d = 16'($urandom);
      frame(n[0] ? oda_pkg::GLOBAL_ADDR : own, 1'b0, 3, {c, ch, d}, ak);
      chk("acks", ak, 5'h0f);
      apply(c, ch, d);
      check_outs();
    end
    for (int k = 0; k < 8; k++) begin
      wb(1'b0, 8'h40 + 8'(4 * k), 32'h0, q);
      chk("input", q, {16'h0, e_in[k]});
    end
    d = 16'($urandom);
    frame(own, 1'b0, 4, {4'h3, 4'h2, d}, ak);
    chk("extra", ak, 5'h0f);
    apply(4'h3, 4'h2, d);
    check_outs();
    frame(own, 1'b0, 2, {4'h3, 4'hf, ~d}, ak);
    check_outs();
    wb(1'b1, 8'h00, 32'h0, q);
    frame(own, 1'b0, 3, {4'h3, 4'hf, ~d}, ak);
    chk("disabled", ak, 5'h00);
    wb(1'b1, 8'h00, 32'h1, q);
    check_outs();
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int k = 0; k < 8; k++) chk("dac_rst", dac_a[k], 16'h0000);
    final_report();
  end
endmodule

bind oda_dac_slave oda_dac_slave_properties #(.MIDSCALE_POR(MIDSCALE_POR)) i_oda_dac_slave_properties (
  .core_clk_i, .rst_n_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .channel_output_o, .power_down_o);

`default_nettype wire
